//--- src/szc_ctrl.sv
// Setpoint view/edit and forced zero/tare control with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module szc_ctrl import szc_pkg::*; #(
	parameter int HOLD_SHORT = HOLD_SHORT_CYC,
	parameter int HOLD_LONG  = HOLD_LONG_CYC,
	parameter int SEC_CYC    = SECOND_CYC
) (
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire szc_pins_t         pins_i,
	input  wire logic              sensor_err_i,
	input  wire logic              maxmin_shown_i,
	input  wire logic [DATA_W-1:0] meas_i,
	output logic [DATA_W-1:0]      display_o,
	output logic [2:0]             secondary_readout_o,
	output logic                   overrange_o,
	output logic                   bank_change_ok_o,
	output logic                   edit_o,
	output logic [2:0]             edit_digit_o,
	output logic [3:0]             level_blink_o,
	output logic [3:0]             alarm_enable_o,
	output logic [DATA_W-1:0]      edit_value_o,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);
	szc_pins_t          sync_a;
	szc_pins_t          sync_b;
	szc_pins_t          pins_d;
	logic [31:0]        cfg;
	logic [DATA_W-1:0]  ref_val;
	szc_readout_t       rd_state;
	szc_zero_t          z_state;
	logic               edit;
	logic [2:0]         digit;
	logic [DATA_W-1:0]  edit_val;
	logic               edit_dis;
	szc_sp_t            sp [4];
	logic [DATA_W-1:0]  offset;
	logic [DATA_W-1:0]  fz_offset;
	logic [27:0]        hold_cnt;
	logic [27:0]        sec_cnt;
	logic [7:0]         idle_sec;
	logic               alarm_rise;
	logic               shift_rise;
	logic               up_rise;
	logic               any_rise;
	logic               zreq;
	logic               zreq_d;
	logic               zrise;
	logic               open_eff;
	logic               zblocked;
	logic               hold_short_hit;
	logic               hold_long_hit;
	logic               idle_expired;
	logic [1:0]         sp_idx;
	logic               wr_go;
	logic [31:0]        next_rdata;
	logic [1:0]         next_rresp;

	function automatic logic [DATA_W-1:0] pow10(input logic [2:0] d);
		case (d)
			3'h0:    pow10 = 24'd1;
			3'h1:    pow10 = 24'd10;
			3'h2:    pow10 = 24'd100;
			3'h3:    pow10 = 24'd1000;
			3'h4:    pow10 = 24'd10000;
			default: pow10 = 24'd100000;
		endcase
	endfunction : pow10

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] st);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		apply_strb = old;
	endfunction : apply_strb

	function automatic szc_readout_t next_level(input szc_readout_t s, input logic bank_en);
		case (s)
			RD_BANK: next_level = RD_LL;
			RD_LL:   next_level = RD_L;
			RD_L:    next_level = RD_H;
			RD_H:    next_level = RD_HH;
			default: next_level = bank_en ? RD_BANK : RD_LL;
		endcase
	endfunction : next_level

	// Pin synchronisers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
			pins_d <= '0;
		end else if (ce_i) begin
			sync_a <= pins_i;
			sync_b <= sync_a;
			pins_d <= sync_b;
		end
	end

	assign alarm_rise = sync_b.alarm & ~pins_d.alarm;
	assign shift_rise = sync_b.shift & ~pins_d.shift;
	assign up_rise    = sync_b.up & ~pins_d.up;
	assign any_rise   = alarm_rise | shift_rise | up_rise;

	// Readout stepping and setpoint edit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rd_state <= RD_BANK;
			edit     <= 1'b0;
			digit    <= DIGIT_SIXTH;
			edit_val <= SP_RESET;
			edit_dis <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				sp[i] <= '{disabled: 1'b0, value: SP_RESET};
			end
		end else if (ce_i) begin
			if (alarm_rise && !(rd_state == RD_BANK && cfg[CFG_ALARM_LOCK])) begin
				if (edit) begin
					sp[sp_idx] <= '{disabled: edit_dis, value: edit_val};
				end
				edit     <= 1'b0;
				rd_state <= next_level(rd_state, cfg[CFG_BANK_EN]);
			end else if (shift_rise && rd_state != RD_BANK) begin
				if (!edit) begin
					edit     <= 1'b1;
					digit    <= DIGIT_SIXTH;
					edit_val <= sp[sp_idx].value;
					edit_dis <= sp[sp_idx].disabled;
				end else begin
					digit <= (digit == 3'h0) ? DIGIT_SIXTH : digit - 3'h1;
				end
			end else if (up_rise && edit) begin
				if (edit_dis) begin
					edit_dis <= 1'b0;
					edit_val <= SP_MIN;
				end else if ($signed(edit_val + pow10(digit)) > SP_MAX) begin
					edit_dis <= 1'b1;
				end else begin
					edit_val <= edit_val + pow10(digit);
				end
			end else if (idle_expired) begin
				edit     <= 1'b0;
				rd_state <= RD_BANK;
			end
		end
	end

	always_comb begin
		case (rd_state)
			RD_LL:   sp_idx = 2'd0;
			RD_L:    sp_idx = 2'd1;
			RD_H:    sp_idx = 2'd2;
			RD_HH:   sp_idx = 2'd3;
			default: sp_idx = 2'd0;
		endcase
	end

	// Idle timer for automatic return
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sec_cnt  <= '0;
			idle_sec <= '0;
		end else if (ce_i) begin
			if (any_rise || rd_state == RD_BANK || cfg[CFG_RETURN_SEL]) begin
				sec_cnt  <= '0;
				idle_sec <= '0;
			end else if (sec_cnt == 28'(SEC_CYC - 1)) begin
				sec_cnt  <= '0;
				idle_sec <= (idle_sec == 8'hFF) ? idle_sec : idle_sec + 8'h01;
			end else begin
				sec_cnt <= sec_cnt + 28'h1;
			end
		end
	end

	assign idle_expired = !cfg[CFG_RETURN_SEL] && rd_state != RD_BANK && !any_rise
		&& idle_sec >= cfg[CFG_RTIME_LSB +: 8] && cfg[CFG_RTIME_LSB +: 8] != 8'h00;

	// Zero request source and lockout
	// Up belongs to the setpoint edit while editing
	assign zreq = (sync_b.up & ~edit & (cfg[CFG_ZLOCK_LSB +: 2] != zero_lock_level_all_blocked))
		| sync_b.ext_zero;
	assign open_eff = sync_b.ext_zero | (cfg[CFG_ZLOCK_LSB +: 2] == zero_lock_level_open);
	assign zblocked = sync_b.ext_reset;
	assign zrise    = zreq & ~zreq_d;
	assign hold_short_hit = zreq && hold_cnt == 28'(HOLD_SHORT);
	assign hold_long_hit  = zreq && hold_cnt == 28'(HOLD_LONG);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			zreq_d   <= 1'b0;
			hold_cnt <= '0;
		end else if (ce_i) begin
			zreq_d   <= zreq;
			hold_cnt <= !zreq ? 28'h0 : (hold_cnt == 28'(HOLD_LONG) ? hold_cnt : hold_cnt + 28'h1);
		end
	end

	// Forced zero and tare; sensor error deliberately not a gate
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			z_state   <= ZS_MEAS;
			offset    <= '0;
			fz_offset <= '0;
		end else if (ce_i && !zblocked) begin
			if (zrise && !maxmin_shown_i) begin
				case (z_state)
					ZS_MEAS: begin
						offset    <= meas_i - ref_val;
						fz_offset <= meas_i - ref_val;
						z_state   <= ZS_FZ;
					end
					default: begin
						if (open_eff) begin
							offset  <= meas_i - ref_val;
							z_state <= ZS_TARE;
						end
					end
				endcase
			end else if (hold_short_hit) begin
				if (z_state == ZS_TARE) begin
					offset  <= fz_offset;
					z_state <= ZS_FZ;
				end else if (z_state == ZS_FZ && !open_eff) begin
					offset  <= '0;
					z_state <= ZS_MEAS;
				end
			end else if (hold_long_hit && open_eff && z_state == ZS_FZ) begin
				offset  <= '0;
				z_state <= ZS_MEAS;
			end
		end
	end

	// Main value tracks input in every readout state
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			display_o <= '0;
		end else if (ce_i) begin
			display_o <= meas_i - offset;
		end
	end

	always_comb begin
		secondary_readout_o = 3'(sp_idx) + ((rd_state == RD_BANK) ? 3'h0 : 3'h1);
		overrange_o         = sensor_err_i && rd_state == RD_BANK;
		bank_change_ok_o    = rd_state == RD_BANK;
		edit_o              = edit;
		edit_digit_o        = digit;
		edit_value_o        = edit_val;
		level_blink_o       = (rd_state == RD_BANK) ? 4'h0 : (4'h1 << sp_idx);
		for (int i = 0; i < 4; i++) begin
			alarm_enable_o[i] = ~sp[i].disabled;
		end
	end

	// AXI4-Lite write path
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cfg          <= CFG_RESET;
			ref_val      <= REF_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce_i) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				if (s_axi_awaddr == ADDR_CFG) begin
					cfg <= apply_strb(cfg, s_axi_wdata, s_axi_wstrb);
				end else if (s_axi_awaddr == ADDR_REFVAL) begin
					ref_val <= DATA_W'(apply_strb({8'h00, ref_val}, s_axi_wdata, s_axi_wstrb));
				end else begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		case (s_axi_araddr)
			ADDR_CFG:    next_rdata = cfg;
			ADDR_REFVAL: next_rdata = {8'h00, ref_val};
			ADDR_STATUS: next_rdata = {26'h0, 2'(z_state), edit, 3'(rd_state)};
			ADDR_OFFSET: next_rdata = {8'h00, offset};
			default: begin
				if (s_axi_araddr[7:4] == ADDR_SP_BASE[7:4] && s_axi_araddr[1:0] == 2'h0) begin
					next_rdata = {sp[s_axi_araddr[3:2]].disabled, 7'h00, sp[s_axi_araddr[3:2]].value};
				end else begin
					next_rresp = RESP_SLVERR;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rresp;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	property p_step_one;
		@(posedge core_clk_i) disable iff (rst_i)
		(ce_i && alarm_rise && rd_state == RD_LL) |=> rd_state == RD_L;
	endproperty
	a_step_one: assert property (p_step_one) else $error("readout did not step");

	property p_lock_view;
		@(posedge core_clk_i) disable iff (rst_i)
		(rd_state == RD_BANK && cfg[CFG_ALARM_LOCK] && !ce_i) or (rd_state == RD_BANK && cfg[CFG_ALARM_LOCK])
			|=> rd_state == RD_BANK;
	endproperty
	a_lock_view: assert property (p_lock_view) else $error("view entered while locked");

	property p_overrange;
		@(posedge core_clk_i) disable iff (rst_i)
		overrange_o |-> (sensor_err_i && bank_change_ok_o);
	endproperty
	a_overrange: assert property (p_overrange) else $error("overrange outside bank position");

	property p_edit_enter;
		@(posedge core_clk_i) disable iff (rst_i)
		(ce_i && shift_rise && !alarm_rise && !edit && rd_state != RD_BANK) |=> edit && digit == DIGIT_SIXTH;
	endproperty
	a_edit_enter: assert property (p_edit_enter) else $error("edit not entered on sixth digit");

	property p_range;
		@(posedge core_clk_i) disable iff (rst_i)
		edit |-> ($signed(edit_val) >= SP_MIN && $signed(edit_val) <= SP_MAX);
	endproperty
	a_range: assert property (p_range) else $error("edit value out of range");

	property p_store;
		@(posedge core_clk_i) disable iff (rst_i)
		(ce_i && alarm_rise && edit && rd_state == RD_LL) |=> sp[0].value == $past(edit_val) && !edit;
	endproperty
	a_store: assert property (p_store) else $error("setpoint not stored");

	property p_fz_zero;
		@(posedge core_clk_i) disable iff (rst_i)
		(ce_i && !zblocked && zrise && !maxmin_shown_i && z_state == ZS_MEAS) |=> z_state == ZS_FZ
			&& offset == DATA_W'($past(meas_i) - $past(ref_val));
	endproperty
	a_fz_zero: assert property (p_fz_zero) else $error("forced zero not executed");

	property p_reset_block;
		@(posedge core_clk_i) disable iff (rst_i)
		zblocked |=> $stable(z_state) && $stable(offset);
	endproperty
	a_reset_block: assert property (p_reset_block) else $error("zero changed under ext reset");

	property p_maxmin;
		@(posedge core_clk_i) disable iff (rst_i)
		(maxmin_shown_i && z_state == ZS_MEAS) |=> z_state == ZS_MEAS;
	endproperty
	a_maxmin: assert property (p_maxmin) else $error("zero executed during max/min");

	property p_tare_cancel;
		@(posedge core_clk_i) disable iff (rst_i)
		(ce_i && !zblocked && hold_short_hit && z_state == ZS_TARE) |=> z_state == ZS_FZ && offset == fz_offset;
	endproperty
	a_tare_cancel: assert property (p_tare_cancel) else $error("tare not cancelled");
endmodule : szc_ctrl
`default_nettype wire

//--- src/szc_pkg.sv
// Constants and types for the setpoint view and zero/tare control block
// Operation
// - Alarm press steps readout: bank, low-low, low, high, high-high, back to bank.
// - Main measured value keeps updating while setpoints are shown.
// - Bank disabled skips bank position; bank changes refused while viewing setpoints.
// - Alarm setting lockout prevents entering setpoint viewing.
// - Viewing works under sensor error; bank position shows overrange word.
// - Shift on a shown setpoint enters edit; level blinks, sixth digit active.
// - Edited setpoint limited to -20000 through 100000.
// - Dashed disable code disables that alarm level's output.
// - Alarm press in edit stores setpoint and moves to next level.
// - Return select OFF auto-returns to bank after idle time; ON stays.
// - Up press in measuring captures offset so display shows zero.
// - Up press in forced zero performs tare; repeated tares accepted.
// - External zero input acts like pressing or holding Up at the open level, whatever the zero lock or edit state.
// - Zero lock: open allows both, tare blocked allows zero, all blocked none.
// - Zero lockout restricts only the front button, not the external input.
// - Open level: hold Up one second in tare returns to forced zero.
// - Open level: hold Up two seconds cancels forced zero.
// - Tare-blocked level: hold one second in forced zero cancels it.
// - While max or min shown, executes ignored, cancels still done.
// - Sensor error does not block zero or tare requests.
// - External reset input blocks all zero and tare requests.
// - Reference value loaded at execute is configurable, default zero.
package szc_pkg;
	localparam int          DATA_W          = 24;
	localparam logic [7:0]  ADDR_CFG        = 8'h00;
	localparam logic [7:0]  ADDR_REFVAL     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS     = 8'h08;
	localparam logic [7:0]  ADDR_OFFSET     = 8'h0C;
	localparam logic [7:0]  ADDR_SP_BASE    = 8'h10;
	localparam int          CFG_BANK_EN     = 0;
	localparam int          CFG_ALARM_LOCK  = 1;
	localparam int          CFG_RETURN_SEL  = 2;
	localparam int          CFG_ZLOCK_LSB   = 3;
	localparam int          CFG_RTIME_LSB   = 8;
	localparam int          SP_DIS_BIT      = 31;
	localparam logic [31:0] CFG_RESET       = 32'h0000_0A01;
	localparam logic [1:0]  zero_lock_level_open         = 2'h0;
	localparam logic [1:0]  zero_lock_level_tare_blocked = 2'h1;
	localparam logic [1:0]  zero_lock_level_all_blocked  = 2'h2;
	localparam logic signed [DATA_W-1:0] SP_MIN   = -24'sd20000;
	localparam logic signed [DATA_W-1:0] SP_MAX   = 24'sd100000;
	localparam logic signed [DATA_W-1:0] SP_RESET = 24'sd0;
	localparam logic signed [DATA_W-1:0] REF_RESET = 24'sd0;
	localparam logic [2:0]  DIGIT_SIXTH     = 3'h5;
	localparam int          CLK_HZ          = 50_000_000;
	localparam int          HOLD_SHORT_MS   = 1000;
	localparam int          HOLD_LONG_MS    = 2000;
	localparam int          SECOND_MS       = 1000;
	localparam int          HOLD_SHORT_CYC  = HOLD_SHORT_MS * (CLK_HZ / 1000);
	localparam int          HOLD_LONG_CYC   = HOLD_LONG_MS * (CLK_HZ / 1000);
	localparam int          SECOND_CYC      = SECOND_MS * (CLK_HZ / 1000);
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum {RD_BANK, RD_LL, RD_L, RD_H, RD_HH} szc_readout_t;
	typedef enum {ZS_MEAS, ZS_FZ, ZS_TARE} szc_zero_t;

	typedef struct packed {
		logic alarm;
		logic shift;
		logic up;
		logic ext_zero;
		logic ext_reset;
	} szc_pins_t;

	typedef struct packed {
		logic       disabled;
		logic [DATA_W-1:0] value;
	} szc_sp_t;
endpackage : szc_pkg

//--- verification/szc_panel.sv
// Operator front buttons and external zero contact model
`timescale 1ns/1ns
`default_nettype none
module szc_panel import szc_pkg::*; (
	input  wire logic     core_clk_i,
	output var szc_pins_t pins_o
);
	initial begin
		pins_o = '0;
	end
	// Same contact timing for front button and external zero input
	task automatic press(input int idx, input int cyc);
		@(posedge core_clk_i);
		pins_o[idx] <= 1'b1;
		repeat (cyc) @(posedge core_clk_i);
		pins_o[idx] <= 1'b0;
		repeat (6) @(posedge core_clk_i);
	endtask : press
	// Level contact such as the external reset
	task automatic set_pin(input int idx, input logic v);
		@(posedge core_clk_i);
		pins_o[idx] <= v;
		repeat (4) @(posedge core_clk_i);
	endtask : set_pin
endmodule : szc_panel
`default_nettype wire

//--- verification/setpoint_view_and_zero_tare_ctrl_test.sv
// Testbench for the setpoint view and zero/tare control block
`timescale 1ns/1ns
`default_nettype none
module setpoint_view_and_zero_tare_ctrl_test import szc_pkg::*;;
	logic              core_clk_i;
	logic              rst_i;
	logic              sensor_err_i;
	logic              maxmin_shown_i;
	logic [DATA_W-1:0] meas_i;
	logic [DATA_W-1:0] display_o;
	szc_pins_t         pins;
	logic [2:0]        readout;
	logic [2:0]        digit;
	logic              overrange;
	logic              bank_ok;
	logic              edit;
	logic [DATA_W-1:0] edit_value;
	logic [3:0]        blink;
	logic [3:0]        alarm_en;
	logic              awv, awr, wv, wr, bv, bre, arv, arr, rv, rre;
	logic [7:0]        awa, ara;
	logic [31:0]       wd, rdat, rd;
	logic [1:0]        bres, rres, rs;
	int                errors;
	int                checks_done;

	szc_panel panel (.core_clk_i(core_clk_i), .pins_o(pins));

	szc_ctrl #(.HOLD_SHORT(20), .HOLD_LONG(40), .SEC_CYC(10)) dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins_i(pins),
		.sensor_err_i(sensor_err_i), .maxmin_shown_i(maxmin_shown_i), .meas_i(meas_i),
		.display_o(display_o), .secondary_readout_o(readout), .overrange_o(overrange),
		.bank_change_ok_o(bank_ok), .edit_o(edit), .edit_digit_o(digit), .level_blink_o(blink),
		.alarm_enable_o(alarm_en), .edit_value_o(edit_value),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdat),
		.s_axi_rresp(rres)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk_i);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bre <= 1'b1;
		do @(posedge core_clk_i); while (!(awr && wr));
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge core_clk_i); while (!bv);
		r = bres;
		bre <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk_i);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do @(posedge core_clk_i); while (!arr);
		arv <= 1'b0;
		do @(posedge core_clk_i); while (!rv);
		d = rdat;
		r = rres;
		rre <= 1'b0;
	endtask : axi_rd

	// One Alarm press, then readout position, indicator and bank permission
	task automatic step(input int exp);
		panel.press(4, 3);
		chk("readout", {29'h0, readout}, 32'(exp));
		chk("blink", {28'h0, blink}, (exp == 0) ? 32'h0 : (32'h1 << (exp - 1)));
		chk("bank ok", {31'h0, bank_ok}, {31'h0, exp == 0});
	endtask : step

	task automatic expect_zero(input logic [1:0] st, input int disp);
		axi_rd(ADDR_STATUS, rd, rs);
		chk("zero state", {30'h0, rd[5:4]}, {30'h0, st});
		chk("display", {8'h00, display_o}, {8'h00, 24'(disp)});
	endtask : expect_zero

	initial begin
		#400000;
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		checks_done = 0;
		rst_i = 1'b1;
		sensor_err_i = 1'b0;
		maxmin_shown_i = 1'b0;
		meas_i = 24'h0003E8;
		{awv, wv, bre, arv, rre} = '0;
		{awa, ara, wd} = '0;
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		axi_rd(ADDR_CFG, rd, rs);
		chk("cfg reset", rd, CFG_RESET);
		chk("edit digit", {29'h0, digit}, {29'h0, DIGIT_SIXTH});
		chk("alarm enable", {28'h0, alarm_en}, 32'h0000000F);
		axi_wr(8'h40, 32'h00000001, rs);
		chk("unmapped write", {30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_wr(ADDR_STATUS, 32'h00000000, rs);
		chk("read-only write", {30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_rd(8'h40, rd, rs);
		chk("unmapped read", {30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_wr(ADDR_CFG, 32'h00000A03, rs);
		step(0);
		axi_wr(ADDR_CFG, 32'h00000A01, rs);
		// Full cycle under sensor error with a moving measurement
		sensor_err_i <= 1'b1;
		for (int i = 1; i <= 5; i++) begin
			meas_i <= 24'(1000 + i);
			step(i % 5);
			chk("overrange", {31'h0, overrange}, {31'h0, i == 5});
			chk("display", {8'h00, display_o}, 32'(1000 + i));
		end
		sensor_err_i <= 1'b0;
		meas_i <= 24'h0003E8;
		// Edit low-low to disabled, low to top limit, high to bottom limit
		step(1);
		panel.press(3, 3);
		chk("edit", {31'h0, edit}, 32'h1);
		chk("edit digit", {29'h0, digit}, {29'h0, DIGIT_SIXTH});
		panel.press(2, 3);
		chk("edit value", {8'h00, edit_value}, 32'h000186A0);
		panel.press(2, 3);
		panel.press(3, 3);
		chk("edit digit", {29'h0, digit}, 32'h00000004);
		step(2);
		chk("alarm enable", {28'h0, alarm_en}, 32'h0000000E);
		panel.press(3, 3);
		panel.press(2, 3);
		step(3);
		panel.press(3, 3);
		repeat (3) panel.press(2, 3);
		step(4);
		step(0);
		axi_rd(ADDR_SP_BASE, rd, rs);
		chk("sp low-low off", {31'h0, rd[SP_DIS_BIT]}, 32'h1);
		axi_rd(ADDR_SP_BASE + 8'h04, rd, rs);
		chk("sp low", {rd[31], 7'h00, rd[23:0]}, 32'h000186A0);
		axi_rd(ADDR_SP_BASE + 8'h08, rd, rs);
		chk("sp high", {rd[31], 7'h00, rd[23:0]}, 32'h00FFB1E0);
		// Timed return after ten idle seconds
		step(1);
		repeat (80) @(posedge core_clk_i);
		chk("no early return", {29'h0, readout}, 32'h1);
		repeat (30) @(posedge core_clk_i);
		chk("auto return", {29'h0, readout}, 32'h0);
		axi_wr(ADDR_CFG, 32'h00000A05, rs);
		step(1);
		repeat (150) @(posedge core_clk_i);
		chk("manual return", {29'h0, readout}, 32'h1);
		axi_wr(ADDR_CFG, 32'h00000A04, rs);
		for (int i = 2; i <= 5; i++) step((i - 1) % 4 + 1);
		axi_wr(ADDR_CFG, 32'h00000A05, rs);
		for (int i = 2; i <= 5; i++) step(i % 5);
		// Forced zero and tare at the open level
		panel.press(2, 3);
		expect_zero(2'h1, 0);
		meas_i <= 24'h0005DC;
		panel.press(2, 3);
		expect_zero(2'h2, 0);
		panel.press(2, 3);
		expect_zero(2'h2, 0);
		panel.press(2, 30);
		expect_zero(2'h1, 500);
		panel.press(2, 50);
		expect_zero(2'h0, 1500);
		axi_wr(ADDR_REFVAL, 32'h00000064, rs);
		panel.press(2, 3);
		expect_zero(2'h1, 100);
		panel.press(2, 50);
		expect_zero(2'h0, 1500);
		axi_wr(ADDR_REFVAL, 32'h00000000, rs);
		// Tare-blocked level
		axi_wr(ADDR_CFG, 32'h00000A0D, rs);
		panel.press(2, 3);
		meas_i <= 24'h000640;
		panel.press(2, 3);
		expect_zero(2'h1, 100);
		panel.press(2, 30);
		expect_zero(2'h0, 1600);
		// All-blocked level, external input still honoured
		axi_wr(ADDR_CFG, 32'h00000A15, rs);
		panel.press(2, 3);
		expect_zero(2'h0, 1600);
		panel.press(1, 3);
		expect_zero(2'h1, 0);
		maxmin_shown_i <= 1'b1;
		meas_i <= 24'h0006A4;
		panel.press(1, 3);
		expect_zero(2'h1, 100);
		panel.press(1, 50);
		expect_zero(2'h0, 1700);
		maxmin_shown_i <= 1'b0;
		sensor_err_i <= 1'b1;
		panel.press(1, 3);
		expect_zero(2'h1, 0);
		panel.press(1, 50);
		expect_zero(2'h0, 1700);
		sensor_err_i <= 1'b0;
		panel.set_pin(0, 1'b1);
		panel.press(1, 3);
		expect_zero(2'h0, 1700);
		panel.set_pin(0, 1'b0);
		give_verdict();
	end
endmodule : setpoint_view_and_zero_tare_ctrl_test
`default_nettype wire
